//--- rtl/amdec_top.sv
// addressing mode decoder and operand address generator
// Notes on behaviour
// - separate spaces; six 12-bit return cells
// - immediate operand is byte after opcode
// - direct: next byte is data address
// - short direct picks 80h-83h from opcode
// - jump target: opcode low nibble, next byte
// - relative: condition, direction, span -15..+16
// - bit direct: opcode bit, next byte address
// - bit test branch: three bytes, signed displacement
// - indirect: opcode bit 4 picks X/Y
// - inherent: one byte, opcode only
// - 40 operations, six groups decoded
// - loads: 4 cycles, zero updated, carry kept
// - immediate-to-memory: 3 bytes, flags kept
// - one data space maps core, peripherals, memory
// - bit test copies bit to carry
`default_nettype none
module amdec_top (
    input  wire logic                     clock,
    input  wire logic                     rst_b,
    input  wire logic [7:0]               pm_data,
    output logic [11:0]                   pm_addr,
    input  wire logic [7:0]               dm_rdata,
    output var amdec_pkg::amdec_dm_req_t  dm_req,
    output var amdec_pkg::amdec_dec_t     dec_info,
    output logic [7:0]                    acc_out,
    output logic                          zero_flag,
    output logic                          carry_flag,
    output logic                          inst_done
);
    // ****************************************
    // state and storage
    // ****************************************
    typedef enum logic [4:0] {
        ST_OP   = 5'h01,
        ST_B2   = 5'h02,
        ST_B3   = 5'h04,
        ST_EXEC = 5'h08,
        ST_PAD  = 5'h10
    } amdec_state_t;

    amdec_state_t           state;
    amdec_state_t           next_state;
    logic [2:0]             cyc;
    logic [11:0]            pc;
    logic [7:0]             opcode;
    logic [7:0]             byte2;
    logic [7:0]             byte3;
    amdec_pkg::amdec_dec_t  dec;
    logic [7:0]             acc;
    logic [7:0]             sdr [4];
    logic [11:0]            stack [amdec_pkg::STACK_DEPTH];
    logic                   z;
    logic                   c;

    // ****************************************
    // data space read
    // ****************************************
    function automatic logic is_sdr(input logic [7:0] a);
        return a[7:2] == amdec_pkg::DA_SDR_BASE[7:2];
    endfunction : is_sdr

    function automatic logic [7:0] read_data(input logic [7:0] a);
        if (a == amdec_pkg::DA_ACC)
            return acc;
        else if (is_sdr(a))
            return sdr[a[1:0]];
        return dm_rdata;
    endfunction : read_data

    // ****************************************
    // decode and address selection
    // ****************************************
    amdec_pkg::amdec_dec_t  dec_now;
    logic                   in_exec;
    logic [7:0]             sd_addr;
    logic [7:0]             op_addr;
    logic                   ld_op_addr;
    logic                   ld_b2_addr;
    logic [7:0]             rd_val;

    assign dec_now    = amdec_pkg::amdec_decode(pm_data);
    assign in_exec    = state == ST_EXEC;
    assign sd_addr    = amdec_pkg::DA_SDR_BASE | {6'h00, pm_data[1:0]};
    assign op_addr    = (dec_now.mode == amdec_pkg::MODE_IND) ? (pm_data[4] ? sdr[1] : sdr[0]) : sd_addr;
    assign ld_op_addr = state == ST_OP && (dec_now.mode == amdec_pkg::MODE_IND
                        || dec_now.mode == amdec_pkg::MODE_SHORT);
    assign ld_b2_addr = state == ST_B2 && (dec.mode == amdec_pkg::MODE_DIR
                        || dec.mode == amdec_pkg::MODE_BITDIR || dec.mode == amdec_pkg::MODE_BITTEST
                        || (dec.mode == amdec_pkg::MODE_IMM && dec.len == amdec_pkg::LEN3));

    // combinational so that acc, sdr and dm_rdata are all in its sensitivity
    always_comb
    begin
        rd_val = read_data(dm_req.addr);
    end

    // ****************************************
    // load and store classes
    // ****************************************
    logic  ld_grp;
    logic  is_store;
    logic  is_ldi_mem;
    logic  is_ldi_a;
    logic  is_load;
    logic  is_bit;
    logic  is_call;
    logic  is_ret;

    assign ld_grp     = dec.grp == amdec_pkg::GRP_LDST;
    assign is_store   = ld_grp && ((opcode[7:4] == amdec_pkg::OPH_LOAD && (opcode == amdec_pkg::OP_LD_DIR_A
                        || opcode[3:2] == amdec_pkg::SUB_LD_SD_A)) || (dec.mode == amdec_pkg::MODE_IND && opcode[2]));
    assign is_ldi_mem = ld_grp && opcode == amdec_pkg::OP_LDI_MEM;
    assign is_ldi_a   = ld_grp && opcode == amdec_pkg::OP_LDI_A;
    assign is_load    = ld_grp && !is_store && !is_ldi_mem && !is_ldi_a;
    assign is_bit     = dec.grp == amdec_pkg::GRP_BIT;
    assign is_call    = dec.mode == amdec_pkg::MODE_EXT && opcode[4];
    assign is_ret     = dec.mode == amdec_pkg::MODE_INH && opcode == amdec_pkg::OP_RET;

    // ****************************************
    // bit handling and branch targets
    // ****************************************
    logic [2:0]   bit_sel;
    logic [7:0]   bit_mask;
    logic         tested;
    logic [7:0]   bit_new;
    logic         cond_true;
    logic [11:0]  span;
    logic [11:0]  rel_tgt;
    logic [11:0]  btb_tgt;
    logic [11:0]  ext_tgt;
    logic         take_jump;
    logic [11:0]  next_pc;

    assign bit_sel   = opcode[3:1];
    assign bit_mask  = 8'h01 << bit_sel;
    assign tested    = rd_val[bit_sel];
    assign bit_new   = opcode[0] ? (rd_val | bit_mask) : (rd_val & ~bit_mask);
    assign cond_true = (opcode[6:5] == 2'h0) ? c : (opcode[6:5] == 2'h1) ? !c
                     : (opcode[6:5] == 2'h2) ? z : !z;
    assign span      = {8'h00, opcode[3:0]};
    assign rel_tgt   = opcode[4] ? (pc - 12'h001 - span) : (pc + span);
    assign btb_tgt   = pc - 12'h002 + {{4{byte3[7]}}, byte3};
    assign ext_tgt   = {opcode[3:0], byte2};
    assign take_jump = in_exec && (dec.mode == amdec_pkg::MODE_EXT || is_ret
                     || (dec.mode == amdec_pkg::MODE_REL && cond_true)
                     || (dec.mode == amdec_pkg::MODE_BITTEST && tested == opcode[0]));
    assign next_pc   = (dec.mode == amdec_pkg::MODE_EXT) ? ext_tgt
                     : (dec.mode == amdec_pkg::MODE_REL) ? rel_tgt
                     : (dec.mode == amdec_pkg::MODE_BITTEST) ? btb_tgt : stack[0];

    // ****************************************
    // write path
    // ****************************************
    logic        wr_go;
    logic        wr_internal;
    logic [7:0]  wr_val;
    logic        last_cyc;

    assign wr_go       = in_exec && (is_store || is_ldi_mem || is_bit);
    assign wr_internal = amdec_pkg::amdec_region(dm_req.addr) == amdec_pkg::RGN_CORE;
    assign wr_val      = is_bit ? bit_new : (is_ldi_mem ? byte3 : acc);
    assign last_cyc    = cyc == dec.cycles - 3'h1;

    // ****************************************
    // sequencer
    // ****************************************
    always_comb
    begin
        case (state)
            ST_OP:   next_state = (dec_now.len != amdec_pkg::LEN1) ? ST_B2 : ST_EXEC;
            ST_B2:   next_state = (dec.len == amdec_pkg::LEN3) ? ST_B3 : ST_EXEC;
            ST_B3:   next_state = ST_EXEC;
            ST_EXEC,
            ST_PAD:  next_state = last_cyc ? ST_OP : ST_PAD;
            default: next_state = ST_OP;
        endcase
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= ST_OP;
            cyc   <= 3'h0;
            pc    <= amdec_pkg::PC_RESET;
        end
        else
        begin
            state <= next_state;
            cyc   <= (state == ST_OP) ? 3'h1 : cyc + 3'h1;
            if (state == ST_OP || state == ST_B2 || state == ST_B3)
                pc <= pc + 12'h001;
            else if (take_jump)
                pc <= next_pc;
        end
    end

    // ****************************************
    // instruction bytes
    // ****************************************
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            opcode <= 8'h00;
            byte2  <= 8'h00;
            byte3  <= 8'h00;
            dec    <= '{amdec_pkg::GRP_CTRL, amdec_pkg::MODE_INH, amdec_pkg::LEN1, amdec_pkg::CYC_CTRL};
        end
        else
        begin
            if (state == ST_OP)
            begin
                opcode <= pm_data;
                dec    <= dec_now;
            end
            if (state == ST_B2)
                byte2 <= pm_data;
            if (state == ST_B3)
                byte3 <= pm_data;
        end
    end

    // ****************************************
    // return stack
    // ****************************************
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < amdec_pkg::STACK_DEPTH; i++)
                stack[i] <= 12'h000;
        end
        else if (in_exec && is_call)
        begin
            stack[0] <= pc;
            for (int i = 1; i < amdec_pkg::STACK_DEPTH; i++)
                stack[i] <= stack[i-1];
        end
        else if (in_exec && is_ret)
        begin
            for (int i = 0; i < amdec_pkg::STACK_DEPTH - 1; i++)
                stack[i] <= stack[i+1];
        end
    end

    // ****************************************
    // data space request
    // ****************************************
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            dm_req <= '{1'b0, 8'h00, 8'h00, amdec_pkg::RGN_ROM};
        else
        begin
            dm_req.wr <= wr_go && !wr_internal;
            if (wr_go && !wr_internal)
                dm_req.wdata <= wr_val;
            if (ld_op_addr)
            begin
                dm_req.addr   <= op_addr;
                dm_req.region <= amdec_pkg::amdec_region(op_addr);
            end
            else if (ld_b2_addr)
            begin
                dm_req.addr   <= pm_data;
                dm_req.region <= amdec_pkg::amdec_region(pm_data);
            end
        end
    end

    // ****************************************
    // accumulator, short direct registers, flags
    // ****************************************
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            acc <= 8'h00;
            z   <= 1'b0;
            c   <= 1'b0;
            for (int i = 0; i < 4; i++)
                sdr[i] <= 8'h00;
        end
        else if (in_exec)
        begin
            if (is_load || is_ldi_a)
            begin
                acc <= is_ldi_a ? byte2 : rd_val;
                z   <= (is_ldi_a ? byte2 : rd_val) == amdec_pkg::BYTE_ZERO;
            end
            if (is_store)
                z <= acc == amdec_pkg::BYTE_ZERO;
            if (wr_go && dm_req.addr == amdec_pkg::DA_ACC)
                acc <= wr_val;
            if (wr_go && is_sdr(dm_req.addr))
                sdr[dm_req.addr[1:0]] <= wr_val;
            if (dec.mode == amdec_pkg::MODE_BITTEST)
                c <= tested;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign pm_addr    = pc;
    assign dec_info   = dec;
    assign acc_out    = acc;
    assign zero_flag  = z;
    assign carry_flag = c;
    assign inst_done  = (state == ST_EXEC || state == ST_PAD) && last_cyc;
endmodule : amdec_top
`default_nettype wire

//--- rtl/amdec_pkg.sv
// addressing mode decoder: shared constants, types and decode functions
`default_nettype none
package amdec_pkg;
    // ****************************************
    // data space map
    // ****************************************
    localparam logic [7:0]  DA_SDR_BASE = 8'h80;
    localparam logic [7:0]  DA_ACC      = 8'hFF;
    localparam logic [7:0]  DA_ROM_END  = 8'h3F;
    localparam logic [7:0]  DA_RAM_END  = 8'hBF;
    localparam int          STACK_DEPTH = 6;
    localparam logic [11:0] PC_RESET    = 12'h000;
    localparam logic [7:0]  BYTE_ZERO   = 8'h00;

    // ****************************************
    // opcode encodings
    // ****************************************
    localparam logic [7:0]  OP_LD_A_DIR = 8'hC0;
    localparam logic [7:0]  OP_LD_DIR_A = 8'hC1;
    localparam logic [7:0]  OP_LDI_A    = 8'hC2;
    localparam logic [7:0]  OP_LDI_MEM  = 8'hC3;
    localparam logic [7:0]  OP_RET      = 8'hE9;
    localparam logic [3:0]  OPH_LOAD    = 4'hC;
    localparam logic [1:0]  SUB_LD_A_SD = 2'h1;
    localparam logic [1:0]  SUB_LD_SD_A = 2'h2;

    // ****************************************
    // lengths and cycle counts
    // ****************************************
    localparam logic [1:0]  LEN1        = 2'h1;
    localparam logic [1:0]  LEN2        = 2'h2;
    localparam logic [1:0]  LEN3        = 2'h3;
    localparam logic [2:0]  CYC_LDST    = 3'h4;
    localparam logic [2:0]  CYC_ARITH   = 3'h4;
    localparam logic [2:0]  CYC_JR      = 3'h2;
    localparam logic [2:0]  CYC_BTB     = 3'h5;
    localparam logic [2:0]  CYC_BIT     = 3'h4;
    localparam logic [2:0]  CYC_JP      = 3'h4;
    localparam logic [2:0]  CYC_CTRL    = 3'h2;

    typedef enum logic [2:0] {GRP_LDST, GRP_ARITH, GRP_BRANCH, GRP_CTRL, GRP_JUMP, GRP_BIT} amdec_grp_t;
    typedef enum logic [3:0] {MODE_IMM, MODE_DIR, MODE_SHORT, MODE_EXT, MODE_REL,
                              MODE_BITDIR, MODE_BITTEST, MODE_IND, MODE_INH} amdec_mode_t;
    typedef enum logic [1:0] {RGN_ROM, RGN_RAM, RGN_PERIPH, RGN_CORE} amdec_region_t;

    typedef struct packed {
        amdec_grp_t  grp;
        amdec_mode_t mode;
        logic [1:0]  len;
        logic [2:0]  cycles;
    } amdec_dec_t;

    typedef struct packed {
        logic          wr;
        logic [7:0]    addr;
        logic [7:0]    wdata;
        amdec_region_t region;
    } amdec_dm_req_t;

    // ****************************************
    // opcode classification
    // ****************************************
    function automatic amdec_dec_t amdec_decode(input logic [7:0] op);
        amdec_dec_t d;
        d = '{GRP_CTRL, MODE_INH, LEN1, CYC_CTRL};
        if (!op[7])
            d = '{GRP_BRANCH, MODE_REL, LEN1, CYC_JR};
        else
        begin
            case (op[6:4])
                3'h0, 3'h1: d = '{GRP_JUMP, MODE_EXT, LEN2, CYC_JP};
                3'h2: d = '{GRP_BRANCH, MODE_BITTEST, LEN3, CYC_BTB};
                3'h3: d = '{GRP_BIT, MODE_BITDIR, LEN2, CYC_BIT};
                3'h4:
                begin
                    if (op[3:2] == 2'h0)
                        d = '{GRP_LDST, op[1] ? MODE_IMM : MODE_DIR, op[1:0] == 2'h3 ? LEN3 : LEN2, CYC_LDST};
                    else if (op[3:2] != 2'h3)
                        d = '{GRP_LDST, MODE_SHORT, LEN1, CYC_LDST};
                end
                3'h5: d = '{GRP_ARITH, MODE_DIR, LEN2, CYC_ARITH};
                default:
                begin
                    if (!op[3])
                        d = '{GRP_LDST, MODE_IND, LEN1, CYC_LDST};
                    else if (op[4])
                        d = '{GRP_ARITH, MODE_INH, LEN1, CYC_ARITH};
                end
            endcase
        end
        return d;
    endfunction : amdec_decode

    function automatic amdec_region_t amdec_region(input logic [7:0] a);
        if (a == DA_ACC || a[7:2] == DA_SDR_BASE[7:2])
            return RGN_CORE;
        else if (a <= DA_ROM_END)
            return RGN_ROM;
        else if (a <= DA_RAM_END)
            return RGN_RAM;
        return RGN_PERIPH;
    endfunction : amdec_region
endpackage : amdec_pkg
`default_nettype wire

//--- sim/amdec_mem_model.sv
// program and data space memory model facing the decoder
`default_nettype none
module amdec_mem_model (
    input  wire logic                     clock,
    input  wire logic [11:0]              pm_addr,
    output logic [7:0]                    pm_data,
    input  wire amdec_pkg::amdec_dm_req_t dm_req,
    output logic [7:0]                    dm_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************
    // separate program and data arrays
    // ****************************************
    logic [7:0] prog [4096];
    logic [7:0] dmem [256];
    assign pm_data  = prog[pm_addr];
    assign dm_rdata = dmem[dm_req.addr];
    always @(posedge clock)
        if (dm_req.wr === 1'b1)
            dmem[dm_req.addr] <= dm_req.wdata;

    task automatic clear();
        for (int i = 0; i < 4096; i++)
            prog[i] = 8'hE8;
        for (int i = 0; i < 256; i++)
            dmem[i] = 8'h00;
    endtask : clear
endmodule : amdec_mem_model
`default_nettype wire

//--- sim/amdec_top_properties.sv
// checker for the addressing mode decoder ports
`default_nettype none
module amdec_top_properties (
    input wire logic                     clock,
    input wire logic                     rst_b,
    input wire logic [7:0]               pm_data,
    input wire logic [11:0]              pm_addr,
    input wire logic [7:0]               dm_rdata,
    input wire amdec_pkg::amdec_dm_req_t dm_req,
    input wire amdec_pkg::amdec_dec_t    dec_info,
    input wire logic [7:0]               acc_out,
    input wire logic                     zero_flag,
    input wire logic                     carry_flag,
    input wire logic                     inst_done
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************
    // instruction tracking
    // ****************************************
    logic [2:0]  cnt;
    logic [11:0] start_pc;
    logic [7:0]  op_q;
    logic [7:0]  b2_q;
    logic [7:0]  b3_q;
    logic        z_q;
    logic        c_q;
    wire         is_ld   = dec_info.grp == amdec_pkg::GRP_LDST;
    wire         ldi_mem = op_q == amdec_pkg::OP_LDI_MEM;
    wire         step    = is_ld || dec_info.grp == amdec_pkg::GRP_ARITH
                           || (dec_info.grp == amdec_pkg::GRP_CTRL && op_q != amdec_pkg::OP_RET);
    wire [1:0]   cc      = op_q[6:5];
    wire         taken   = cc[1] ? (zero_flag ^ cc[0]) : (carry_flag ^ cc[0]);
    wire [11:0]  rel_tgt = op_q[4] ? start_pc - {8'h00, op_q[3:0]} : start_pc + {8'h00, op_q[3:0]} + 12'h001;

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt <= 3'h0;
            {start_pc, op_q, b2_q, b3_q, z_q, c_q} <= '0;
        end
        else
        begin
            cnt <= inst_done ? 3'h0 : cnt + 3'h1;
            if (cnt == 3'h0)
                {start_pc, op_q, z_q, c_q} <= {pm_addr, pm_data, zero_flag, carry_flag};
            if (cnt == 3'h1)
                b2_q <= pm_data;
            if (cnt == 3'h2)
                b3_q <= pm_data;
        end
    end

    default clocking dflt @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    sequence s_ldi_mem_end;
        inst_done && ldi_mem;
    endsequence

    a_cycle_count: assert property (inst_done |-> cnt + 3'h1 == (is_ld ? 3'h4 : dec_info.cycles))
        else $error("instruction cycle count wrong");
    a_inst_length: assert property (inst_done && step |=> pm_addr == start_pc + {10'h000, dec_info.len})
        else $error("program counter not advanced by instruction length");
    a_jump_target: assert property (inst_done && dec_info.grp == amdec_pkg::GRP_JUMP
        |=> pm_addr == {op_q[3:0], b2_q})
        else $error("extended target wrong");
    a_rel_branch: assert property (inst_done && dec_info.mode == amdec_pkg::MODE_REL
        |=> pm_addr == (taken ? rel_tgt : start_pc + 12'h001))
        else $error("relative branch destination wrong");
    a_direct_addr: assert property (inst_done && is_ld && (dec_info.mode == amdec_pkg::MODE_DIR || ldi_mem)
        |-> dm_req.addr == b2_q)
        else $error("direct operand address wrong");
    a_short_addr: assert property (inst_done && dec_info.mode == amdec_pkg::MODE_SHORT
        |-> dm_req.addr == {6'h20, op_q[1:0]})
        else $error("short direct address wrong");
    a_ldi_mem_write: assert property (s_ldi_mem_end |=> dm_req.wr && dm_req.addr == b2_q && dm_req.wdata == b3_q)
        else $error("immediate store not written");
    a_ldi_mem_flags: assert property (s_ldi_mem_end |=> zero_flag == z_q && carry_flag == c_q)
        else $error("immediate store changed flags");
    a_load_carry: assert property (inst_done && is_ld |=> carry_flag == c_q)
        else $error("load changed carry");
    a_load_zero: assert property (inst_done && is_ld && !ldi_mem |=> zero_flag == (acc_out == 8'h00))
        else $error("zero flag does not follow accumulator");
    a_bit_test_zero: assert property (inst_done && dec_info.mode == amdec_pkg::MODE_BITTEST |=> zero_flag == z_q)
        else $error("bit test changed zero flag");
endmodule : amdec_top_properties

bind amdec_top amdec_top_properties u_props (.clock(clock), .rst_b(rst_b), .pm_data(pm_data),
    .pm_addr(pm_addr), .dm_rdata(dm_rdata), .dm_req(dm_req), .dec_info(dec_info), .acc_out(acc_out),
    .zero_flag(zero_flag), .carry_flag(carry_flag), .inst_done(inst_done));
`default_nettype wire

//--- sim/tb_top.sv
// testbench running load/store and branch programs through the decoder
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************
    // bench and scenarios
    // ****************************************
    logic                     clock = 1'b0;
    logic                     rst_b = 1'b0;
    logic [7:0]               pm_data;
    logic [11:0]              pm_addr;
    logic [7:0]               dm_rdata;
    amdec_pkg::amdec_dm_req_t dm_req;
    amdec_pkg::amdec_dec_t    dec_info;
    logic [7:0]               acc_out;
    logic                     zero_flag;
    logic                     carry_flag;
    logic                     inst_done;
    int                       err_count = 0;
    int                       num_checks = 0;

    always #10 clock = ~clock;

    amdec_top dut (.clock(clock), .rst_b(rst_b), .pm_data(pm_data), .pm_addr(pm_addr),
        .dm_rdata(dm_rdata), .dm_req(dm_req), .dec_info(dec_info), .acc_out(acc_out),
        .zero_flag(zero_flag), .carry_flag(carry_flag), .inst_done(inst_done));
    amdec_mem_model mem (.clock(clock), .pm_addr(pm_addr), .pm_data(pm_data), .dm_req(dm_req),
        .dm_rdata(dm_rdata));

    task automatic results();
        if (err_count == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic restart();
        @(posedge clock);
        rst_b <= 1'b0;
        repeat (5) @(posedge clock);
        chk(pm_addr, 12'h000);
        chk({2'h0, inst_done, dm_req.wr, acc_out}, 12'h000);
        chk({10'h000, zero_flag, carry_flag}, 12'h000);
        mem.clear();
    endtask : restart

    task automatic load(input logic [11:0] a, input logic [7:0] b[$]);
        foreach (b[i])
            mem.prog[a + 12'(i)] = b[i];
    endtask : load

    task automatic run(input int n);
        int k;
        int t;
        k = 0;
        t = 0;
        rst_b <= 1'b1;
        while (k < n)
        begin
            @(negedge clock);
            t++;
            if (inst_done === 1'b1)
                k++;
            if (t > 400)
            begin
                err_count++;
                $display("Error at %0t: instruction did not complete", $time);
                break;
            end
        end
    endtask : run

    task automatic scen_load();
        restart();
        mem.dmem[8'h5A] = 8'h45;
        load(12'h000, '{8'hC2, 8'h00, 8'hC3, 8'h40, 8'h5A, 8'hC0, 8'h40, 8'hC8, 8'hC2, 8'h00,
                        8'hE0, 8'hC1, 8'h60, 8'hC9, 8'hC2, 8'h77, 8'hF4, 8'hC4});
        run(11);
        chk(pm_addr, 12'h012);
        chk({4'h0, acc_out}, 12'h05A);
        chk({4'h0, mem.dmem[8'h40]}, 12'h05A);
        chk({4'h0, mem.dmem[8'h60]}, 12'h045);
        chk({4'h0, mem.dmem[8'h45]}, 12'h077);
        chk({10'h000, zero_flag, carry_flag}, 12'h000);
        chk({10'h000, dm_req.region}, {10'h000, amdec_pkg::RGN_CORE});
        chk({8'h00, dec_info.mode}, {8'h00, amdec_pkg::MODE_SHORT});
    endtask : scen_load

    task automatic scen_branch();
        restart();
        mem.dmem[8'h50] = 8'h01;
        load(12'h000, '{8'hC2, 8'h00, 8'hA1, 8'h50, 8'h03, 8'h00, 8'hB3, 8'h50, 8'h03});
        load(12'h00C, '{8'h91, 8'h23, 8'h35, 8'hA4, 8'h50, 8'h10});
        load(12'h01E, '{8'h82, 8'h34, 8'h32});
        load(12'h123, '{8'hE9});
        run(11);
        chk(pm_addr, 12'h235);
        chk({10'h000, zero_flag, carry_flag}, 12'h002);
        chk({4'h0, mem.dmem[8'h50]}, 12'h003);
    endtask : scen_branch

    initial
    begin
        mem.clear();
        scen_load();
        scen_branch();
        results();
    end
endmodule : tb_top
`default_nettype wire
